// ===== rtl/idle_tick.v
`timescale 1ns/1ps
`include "seq_defs.vh"
module idle_tick #(
  parameter TICK_CYCLES = `IDLE_UNIT_CYC
) (
  input  wire pclk,
  input  wire presetn,
  input  wire run,
  output reg  tick
);
  reg [`TICK_W-1:0] cnt_r;

  // One pulse per idle unit while run is high
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= {`TICK_W{1'b0}};
      tick  <= 1'b0;
    end else if (!run) begin
      cnt_r <= {`TICK_W{1'b0}};
      tick  <= 1'b0;
    end else if (cnt_r == TICK_CYCLES[`TICK_W-1:0] - 1'b1) begin
      cnt_r <= {`TICK_W{1'b0}};
      tick  <= 1'b1; // RULE7
    end else begin
      cnt_r <= cnt_r + 1'b1;
      tick  <= 1'b0;
    end
  end
endmodule

// ===== rtl/seq_defs.vh
`ifndef SEQ_DEFS_VH
`define SEQ_DEFS_VH
// Register indices (printed offsets), byte address = 4 * index
`define IDX_SLOT_FIRST     8'h0f
`define IDX_SLOT_FIVE      8'h13
`define IDX_SLOT_SIX       8'h14
`define IDX_SLOT_LAST      8'h16
`define IDX_CTRL           8'h0c
`define IDX_STATUS         8'h0d
// Control register fields
`define CTRL_GO_BIT        0
// Slot field layout
`define SLOT_IDLE_BIT      7
`define SLOT_VAL_MSB       6
`define SLOT_RESET         8'h00
`define SLOT_COUNT         8
`define SLOT_FIRST_PTR     3'd0
`define SLOT_LAST_PTR      3'd7
// Timing
`define CLK_HZ             40000000
`define IDLE_UNIT_MS       10
`define IDLE_UNIT_CYC      ((`CLK_HZ / 1000) * `IDLE_UNIT_MS)
`define TICK_W             19
`endif

// ===== rtl/waveform_sequence_slots.v
// How it works
// (RULE1) Slot bit 7 set: low seven bits are an idle time, no waveform.
// (RULE2) Idle duration equals slot value times 10 ms.
// (RULE3) Slot bit 7 clear: bits 6..0 select a library waveform index.
// (RULE4) Setting the go bit starts playback at the first slot.
// (RULE5) After a slot finishes, advance to next slot if its id is non-zero.
// (RULE6) Stop at a zero identifier or after the eighth slot.
// (RULE7) Idle timed by counting 10 ms ticks down to zero.
//
// The implementer's own choice: the APB slave port.
`timescale 1ns/1ps
`include "seq_defs.vh"
module waveform_sequence_slots #(
  parameter TICK_CYCLES = `IDLE_UNIT_CYC
) (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire        wave_done,
  output reg         wave_start,
  output reg  [6:0]  wave_index,
  output reg         idle_active,
  output reg         seq_busy
);
  localparam S_IDLE  = 4'b0001;
  localparam S_FETCH = 4'b0010;
  localparam S_PLAY  = 4'b0100;
  localparam S_WAIT  = 4'b1000;

  reg  [7:0] slot_r [0:`SLOT_COUNT-1];
  reg  [3:0] state_r;
  reg  [2:0] ptr_r;
  reg  [6:0] left_r;
  reg        go_r;
  reg        done_s1_r;
  reg        done_s2_r;
  wire       tick;
  wire [7:0] cur;
  wire [7:0] idx;
  wire       in_slots;
  wire       is_ctrl;
  wire       is_stat;
  wire       wr;
  wire       acc;
  reg  [3:0] state_nxt;
  reg  [2:0] ptr_nxt;
  reg  [6:0] left_nxt;
  reg        go_nxt;
  reg        start_nxt;
  reg  [6:0] index_nxt;
  reg        idle_nxt;
  reg        busy_nxt;
  reg        done_d_r;
  wire       done_rise;
  wire [7:0] slot_off;
  wire [2:0] slot_sel;
  wire [7:0] slot_we;
  wire       go_req;
  wire       slot_end;
  wire       last_slot;

  ////////////////////////////////////////////////////////////////////
  // APB decode
  assign idx      = paddr[9:2];
  assign in_slots = (idx >= `IDX_SLOT_FIRST) && (idx <= `IDX_SLOT_LAST)
                    && (paddr[1:0] == 2'b00) && (paddr[11:10] == 2'b00);
  assign is_ctrl  = (paddr == {2'b00, `IDX_CTRL, 2'b00});
  assign is_stat  = (paddr == {2'b00, `IDX_STATUS, 2'b00});
  assign acc      = psel && penable && pready;
  assign wr       = acc && pwrite;
  assign cur      = slot_r[ptr_r];
  assign slot_off = idx - `IDX_SLOT_FIRST;
  assign slot_sel = slot_off[2:0];
  assign slot_we  = (wr && in_slots) ? (8'h01 << slot_sel) : 8'h00;

  // Zero-wait-state slave: pready high in every access phase
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !(in_slots || is_ctrl || is_stat);
      prdata  <= 32'h0000_0000;
      if (psel && !penable && !pwrite) begin
        if (in_slots)
          prdata <= {24'h00_0000, slot_r[slot_sel]};
        else if (is_ctrl)
          prdata <= {31'h0000_0000, go_r};
        else if (is_stat)
          prdata <= {28'h000_0000, 1'b0, ptr_r};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Slot storage
  genvar g;
  generate
    for (g = 0; g < `SLOT_COUNT; g = g + 1) begin : slots
      always @(posedge pclk or negedge presetn) begin
        if (!presetn)
          slot_r[g] <= `SLOT_RESET;
        else if (slot_we[g])
          slot_r[g] <= pwdata[7:0];
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////
  // Done synchroniser
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_s1_r <= 1'b0;
      done_s2_r <= 1'b0;
      done_d_r  <= 1'b0;
    end else begin
      done_s1_r <= wave_done;
      done_s2_r <= done_s1_r;
      done_d_r  <= done_s2_r;
    end
  end

  // Edge only: a done level still high must not end the next wave
  assign done_rise = done_s2_r && !done_d_r;

  idle_tick #(.TICK_CYCLES(TICK_CYCLES)) u_tick (
    .pclk    (pclk),
    .presetn (presetn),
    .run     (state_r == S_WAIT),
    .tick    (tick)
  );

  ////////////////////////////////////////////////////////////////////
  // Sequencer next state
  assign go_req    = wr && is_ctrl && pwdata[`CTRL_GO_BIT];
  assign last_slot = (ptr_r == `SLOT_LAST_PTR);
  assign slot_end  = (left_r == 7'h00) || (tick && left_r == 7'h01);

  always @* begin
    state_nxt = state_r;
    ptr_nxt   = ptr_r;
    left_nxt  = left_r;
    go_nxt    = go_r;
    start_nxt = 1'b0;
    index_nxt = wave_index;
    idle_nxt  = idle_active;
    busy_nxt  = seq_busy;
    case (state_r)
      S_IDLE: begin
        if (go_req) begin
          go_nxt    = 1'b1;
          ptr_nxt   = `SLOT_FIRST_PTR; // RULE4
          busy_nxt  = 1'b1;
          state_nxt = S_FETCH;
        end
      end
      S_FETCH: begin
        if (cur == `SLOT_RESET) begin
          go_nxt    = 1'b0;
          busy_nxt  = 1'b0;
          state_nxt = S_IDLE; // RULE6
        end else if (cur[`SLOT_IDLE_BIT]) begin
          left_nxt  = cur[`SLOT_VAL_MSB:0]; // RULE2
          idle_nxt  = 1'b1; // RULE1
          state_nxt = S_WAIT;
        end else begin
          index_nxt = cur[`SLOT_VAL_MSB:0]; // RULE3
          start_nxt = 1'b1;
          state_nxt = S_PLAY;
        end
      end
      S_PLAY: begin
        if (done_rise) begin
          state_nxt = S_WAIT; // RULE5
        end
      end
      S_WAIT: begin
        if (slot_end) begin
          idle_nxt = 1'b0;
          left_nxt = 7'h00;
          if (last_slot) begin
            go_nxt    = 1'b0;
            busy_nxt  = 1'b0;
            state_nxt = S_IDLE; // RULE6
          end else begin
            ptr_nxt   = ptr_r + 3'd1; // RULE5
            state_nxt = S_FETCH;
          end
        end else if (tick) begin
          left_nxt = left_r - 7'h01; // RULE7
        end
      end
      default: begin
        go_nxt    = 1'b0;
        idle_nxt  = 1'b0;
        busy_nxt  = 1'b0;
        state_nxt = S_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////
  // Sequencer registers
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r     <= S_IDLE;
      ptr_r       <= `SLOT_FIRST_PTR;
      left_r      <= 7'h00;
      go_r        <= 1'b0;
      wave_start  <= 1'b0;
      wave_index  <= 7'h00;
      idle_active <= 1'b0;
      seq_busy    <= 1'b0;
    end else begin
      state_r     <= state_nxt;
      ptr_r       <= ptr_nxt;
      left_r      <= left_nxt;
      go_r        <= go_nxt;
      wave_start  <= start_nxt;
      wave_index  <= index_nxt;
      idle_active <= idle_nxt;
      seq_busy    <= busy_nxt;
    end
  end
endmodule

// ===== verif/seq_checker.sv
`timescale 1ns/1ps
module seq_checker #(parameter TICK_CYCLES = 20) (
  input logic        pclk,
  input logic        presetn,
  input logic        psel,
  input logic        penable,
  input logic        pwrite,
  input logic [11:0] paddr,
  input logic [31:0] pwdata,
  input logic [31:0] prdata,
  input logic        pready,
  input logic        pslverr,
  input logic        wave_done,
  input logic        wave_start,
  input logic [6:0]  wave_index,
  input logic        idle_active,
  input logic        seq_busy
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_go;
    psel && penable && pwrite && paddr == 12'h030 && pwdata[0];
  endsequence
  sequence s_done;
    $rose(wave_done) && seq_busy && !idle_active;
  endsequence
  a_idle_no_wave: assert property (idle_active |-> !wave_start)
    else $error("wave start in idle");
  a_idle_in_run: assert property (idle_active |-> seq_busy)
    else $error("idle outside run");
  a_wave_in_run: assert property (wave_start |-> seq_busy)
    else $error("wave start outside run");
  a_go_starts: assert property (s_go and !seq_busy |-> ##[1:3] seq_busy)
    else $error("go ignored");
  a_done_moves: assert property (s_done |-> ##[1:10]
    (wave_start || idle_active || !seq_busy))
    else $error("no advance");
  a_start_pulse: assert property (wave_start |=> !wave_start)
    else $error("start longer than one cycle");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_stop_quiet: assert property (!seq_busy |-> !wave_start)
    else $error("start while stopped");
  a_zero_wait: assert property (psel && penable |-> pready)
    else $error("no ready");
endmodule
bind waveform_sequence_slots seq_checker #(
  .TICK_CYCLES (TICK_CYCLES)
) u_chk (
  .pclk        (pclk),
  .presetn     (presetn),
  .psel        (psel),
  .penable     (penable),
  .pwrite      (pwrite),
  .paddr       (paddr),
  .pwdata      (pwdata),
  .prdata      (prdata),
  .pready      (pready),
  .pslverr     (pslverr),
  .wave_done   (wave_done),
  .wave_start  (wave_start),
  .wave_index  (wave_index),
  .idle_active (idle_active),
  .seq_busy    (seq_busy)
);

// ===== verif/waveform_sequence_slots_tb_top.sv
`timescale 1ns/1ps
module waveform_sequence_slots_tb_top;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic        pready, pslverr, wave_start, idle_active, seq_busy, err;
  logic        wave_done = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic [6:0]  wave_index, q[$];
  logic [7:0]  slots[8] = '{8'h01, 8'h02, 8'h03, 8'h04,
                            8'h82, 8'h7f, 8'h06, 8'h07};
  int          num_errors = 0, tests_run = 0, idl = 0, dcnt = 0;
  localparam int TICK = 20;
  waveform_sequence_slots #(
    .TICK_CYCLES (TICK)
  ) u_waveform_sequence_slots (
    .pclk        (pclk),
    .presetn     (presetn),
    .psel        (psel),
    .penable     (penable),
    .pwrite      (pwrite),
    .paddr       (paddr),
    .pwdata      (pwdata),
    .prdata      (prdata),
    .pready      (pready),
    .pslverr     (pslverr),
    .wave_done   (wave_done),
    .wave_start  (wave_start),
    .wave_index  (wave_index),
    .idle_active (idle_active),
    .seq_busy    (seq_busy)
  );
  initial forever #12.5 pclk = ~pclk;
  // Waveform player: done high for three cycles, rising five cycles after each start
  always @(posedge pclk) begin
    if (wave_start) q.push_back(wave_index);
    if (idle_active) idl++;
    dcnt <= wave_start ? 6 : (dcnt > 0 ? dcnt - 1 : 0);
    wave_done <= dcnt inside {[1:3]};
  end
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk) penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      num_errors++;
      $display("unexpected at %0t: got %h, expected %h", $time, g, e);
    end
  endtask
  task wrap_up;
    $display("compares %0d, mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task t_regs;
    apb(0, 12'h050, 32'h0);
    chk(rd, 32'h0);
    apb(1, 12'h04c, 32'hffff_ff85);
    apb(0, 12'h04c, 32'h0);
    chk(rd, 32'h85);
    apb(0, 12'hffc, 32'h0);
    chk(err, 32'h1);
    $display("register test end");
  endtask
  task t_run(input logic [7:0] six, input int nw, input logic [2:0] stop_at);
    q = {};
    idl = 0;
    apb(1, 12'h050, {24'h0, six});
    apb(1, 12'h030, 32'h1);
    apb(0, 12'h030, 32'h0);
    chk(rd, 32'h1);
    chk(seq_busy, 1'b1);
    repeat (3) @(posedge pclk);
    while (seq_busy) @(posedge pclk);
    apb(0, 12'h034, 32'h0);
    chk(rd, {29'h0, stop_at});
    chk(q.size(), nw);
    chk(q[0], slots[0][6:0]);
    chk((idl >= 2 * TICK) && (idl <= 2 * TICK + 2), 1'b1);
    $display("sequence test end");
  endtask
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    t_regs;
    for (int i = 0; i < 8; i++) begin
      apb(1, 12'h03c + 12'(4 * i), {24'h0, slots[i]});
    end
    t_run(8'h7f, 7, 3'd7);
    chk(q[4], 7'h7f);
    t_run(8'h00, 4, 3'd5);
    wrap_up;
  end
  initial begin
    #200us;
    num_errors++;
    wrap_up;
  end
endmodule
